// [rtl/flash_bus_cycle.v]
// one asynchronous flash bus cycle: write or read with cs/oe/we strobes
`timescale 1ns/1ps
`include "flash_seq_defs.vh"
module flash_bus_cycle (
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire is_write,
  input wire [19:0] addr,
  input wire [15:0] wdata,
  input wire [15:0] dq_i,
  output reg done,
  output reg [15:0] rdata,
  output reg [19:0] fa,
  output reg [15:0] dq_o,
  output reg dq_oe,
  output reg ce_n,
  output reg oe_n,
  output reg we_n
);
  localparam S_IDLE = 2'd0;
  localparam S_STROBE = 2'd1;
  localparam S_GAP = 2'd2;
  // strobe hold in cycles: least access time plus three sync stages
  localparam [7:0] HOLD_CYC = `STROBE_CYC + 3;
  localparam [7:0] GAP_CYC = `STROBE_CYC;
  reg [1:0] state_reg;
  reg [7:0] cnt_reg;
  reg wr_reg;
  reg [15:0] s1_reg, s2_reg, s3_reg;
  // pin data passes three flops; used once stage two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 16'h0000;
      s2_reg <= 16'h0000;
      s3_reg <= 16'h0000;
    end else begin
      s1_reg <= dq_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      cnt_reg <= 8'h00;
      wr_reg <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      fa <= 20'h00000;
      dq_o <= 16'h0000;
      dq_oe <= 1'b0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
    end else begin
      done <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start) begin
            fa <= addr;
            dq_o <= wdata;
            dq_oe <= is_write;
            wr_reg <= is_write;
            ce_n <= 1'b0;
            oe_n <= is_write;
            we_n <= ~is_write;
            cnt_reg <= 8'h00;
            state_reg <= S_STROBE;
          end
        end
        S_STROBE: begin
          cnt_reg <= cnt_reg + 8'h01;
          // strobe held the least access time plus sync latency, for writes as for reads
          if (cnt_reg >= HOLD_CYC && (wr_reg || s2_reg == s3_reg)) begin
            if (!wr_reg)
              rdata <= s3_reg;
            ce_n <= 1'b1; // toggling ce between reads refreshes status [R02]
            oe_n <= 1'b1;
            we_n <= 1'b1;
            cnt_reg <= 8'h00;
            state_reg <= S_GAP;
          end
        end
        S_GAP: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == GAP_CYC) begin
            dq_oe <= 1'b0;
            done <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // flash_bus_cycle

// [rtl/flash_seq_defs.vh]
// constants for the flash program/erase host sequencer
`ifndef FLASH_SEQ_DEFS_VH
`define FLASH_SEQ_DEFS_VH
// apb register byte offsets
`define REG_CTRL 12'h000
`define REG_ADDR 12'h004
`define REG_DATA 12'h008
`define REG_STAT 12'h00c
`define REG_RDAT 12'h010
// flash command codes
`define CMD_READ_ARRAY 8'hff
`define CMD_ERASE_SETUP 8'h20
`define CMD_CONFIRM 8'hd0
`define CMD_PROG_SETUP 8'h40
`define CMD_SUSPEND 8'hb0
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_PROT_SETUP 8'hc0
// operation codes in ctrl[3:0]
`define OP_PROGRAM 4'h1
`define OP_ERASE 4'h2
`define OP_SUSPEND 4'h3
`define OP_RESUME 4'h4
`define OP_READ_ARRAY 4'h5
`define OP_CLEAR 4'h6
`define OP_PROT 4'h7
`define OP_READ_STATUS 4'h8
`define OP_READ_WORD 4'h9
// status word bit positions
`define ST_LOCK 1
`define ST_PSUS 2
`define ST_SUPPLY 3
`define ST_PERR 4
`define ST_EERR 5
`define ST_ESUS 6
`define ST_READY 7
// bus strobe timing: ns per phase and cycles (least time, round up)
`define STROBE_NS 70
`define CLK_NS 10
`define STROBE_CYC ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// [rtl/flash_seq_host.v]
// host sequencer issuing flash program/erase/suspend command cycles from apb
// Rules of the document this block is written against
// R01: program is setup 40 then data, same address
// R02: toggle chip select between status reads
// R03: ready flag bit 7 means machine idle
// R04: write read-array FF after last operation; host writes FF only when ctrl requests OP_READ_ARRAY or an unassigned op code, not by itself
// R05: program error flag bit 4 reported
// R06: lock abort flag bit 1 reported
// R07: lock,supply,program flags encode program outcome
// R08: supply error blocks programs until cleared
// R09: lock or supply error blocks erases
// R10: error flags cleared only by clear command
// R11: invalid sequence sets program and erase errors
// R12: erase failure sets erase error only
// R13: erase is setup 20 then confirm D0
// R14: program suspended flag shows halted program
// R15: erase suspended flag shows halted erase
// R16: program suspend allows read array, resume D0
// R17: erase suspend allows reads, programs elsewhere
// R18: status, suspend, resume at any address
// R19: protection program is C0 then data
// R20: out-of-range protection address flagged error
// R21: error flags accumulate across a series
// R22: status only on low eight data lines
// R23: after suspend poll ready, bounded wait
`timescale 1ns/1ps
`include "flash_seq_defs.vh"
module flash_seq_host (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [15:0] dq_i,
  output wire [19:0] fa,
  output wire [15:0] dq_o,
  output wire dq_oe,
  output wire ce_n,
  output wire oe_n,
  output wire we_n,
  output reg busy
);
  localparam P_IDLE = 3'd0;
  localparam P_FIRST = 3'd1;
  localparam P_SECOND = 3'd2;
  localparam P_POLL_CMD = 3'd3;
  localparam P_POLL = 3'd4;
  localparam P_READ = 3'd5;
  reg [2:0] state_reg;
  reg [3:0] op_reg;
  reg poll_reg;
  reg [19:0] addr_reg;
  reg [15:0] data_reg;
  reg [7:0] status_reg;
  reg [15:0] rword_reg;
  reg refused_reg;
  reg cyc_start;
  reg cyc_write;
  reg [19:0] cyc_addr;
  reg [15:0] cyc_wdata;
  wire cyc_done;
  wire [15:0] cyc_rdata;
  flash_bus_cycle u_cyc (
    .pclk(pclk),
    .presetn(presetn),
    .start(cyc_start),
    .is_write(cyc_write),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .dq_i(dq_i),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .fa(fa),
    .dq_o(dq_o),
    .dq_oe(dq_oe),
    .ce_n(ce_n),
    .oe_n(oe_n),
    .we_n(we_n)
  );
  // first command code of an operation; 8-bit codes ride the low lines
  function [15:0] first_code;
    input [3:0] op;
    begin
      case (op)
        `OP_PROGRAM: first_code = {8'h00, `CMD_PROG_SETUP}; // [R01]
        `OP_ERASE: first_code = {8'h00, `CMD_ERASE_SETUP}; // [R13]
        `OP_SUSPEND: first_code = {8'h00, `CMD_SUSPEND}; // [R14] [R15]
        `OP_RESUME: first_code = {8'h00, `CMD_CONFIRM}; // [R16]
        `OP_CLEAR: first_code = {8'h00, `CMD_CLEAR_STATUS}; // [R10]
        `OP_PROT: first_code = {8'h00, `CMD_PROT_SETUP}; // [R19]
        `OP_READ_STATUS: first_code = {8'h00, `CMD_READ_STATUS};
        default: first_code = {8'h00, `CMD_READ_ARRAY}; // [R04] [R17]
      endcase
    end
  endfunction
  // host-side refusal mirrors the device's lockouts on the last seen status
  function refuse;
    input [3:0] op;
    input [7:0] st;
    begin
      case (op)
        `OP_PROGRAM: refuse = st[`ST_SUPPLY]; // [R08]
        `OP_ERASE: refuse = st[`ST_SUPPLY] | st[`ST_LOCK]; // [R09]
        default: refuse = 1'b0;
      endcase
    end
  endfunction
  wire two_cycle = (op_reg == `OP_PROGRAM) || (op_reg == `OP_ERASE) || (op_reg == `OP_PROT);
  wire first_busy = cyc_start || state_reg != P_IDLE;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= P_IDLE;
      op_reg <= 4'h0;
      poll_reg <= 1'b0;
      addr_reg <= 20'h00000;
      data_reg <= 16'h0000;
      status_reg <= 8'h80;
      rword_reg <= 16'h0000;
      refused_reg <= 1'b0;
      cyc_start <= 1'b0;
      cyc_write <= 1'b0;
      cyc_addr <= 20'h00000;
      cyc_wdata <= 16'h0000;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      busy <= 1'b0;
    end else begin
      cyc_start <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        // answer one cycle after setup: access phase lasts exactly one cycle
        pready <= 1'b1;
        prdata <= 32'h00000000;
        if (pwrite) begin
          case (paddr)
            `REG_ADDR: addr_reg <= pwdata[19:0];
            `REG_DATA: data_reg <= pwdata[15:0];
            `REG_CTRL: begin
              if (first_busy)
                pslverr <= 1'b1;
              else if (refuse(pwdata[3:0], status_reg))
                refused_reg <= 1'b1;
              else begin
                op_reg <= pwdata[3:0];
                poll_reg <= pwdata[4];
                refused_reg <= 1'b0;
                cyc_start <= 1'b1;
                cyc_write <= (pwdata[3:0] != `OP_READ_WORD);
                cyc_wdata <= first_code(pwdata[3:0]);
                cyc_addr <= addr_reg; // any address is fine for one-cycle codes [R18]
                state_reg <= P_FIRST;
                busy <= 1'b1;
              end
            end
            default: pslverr <= 1'b1;
          endcase
        end else begin
          case (paddr)
            `REG_ADDR: prdata <= {12'h000, addr_reg};
            `REG_DATA: prdata <= {16'h0000, data_reg};
            `REG_CTRL: prdata <= {27'h0, poll_reg, op_reg};
            `REG_STAT: prdata <= {22'h0, refused_reg, busy, status_reg}; // [R03] [R05] [R06] [R07] [R11] [R12]
            `REG_RDAT: prdata <= {16'h0000, rword_reg};
            default: pslverr <= 1'b1;
          endcase
        end
      end
      case (state_reg)
        P_IDLE: ;
        P_FIRST: begin
          if (cyc_done) begin
            if (op_reg == `OP_READ_WORD) begin
              rword_reg <= cyc_rdata;
              state_reg <= P_IDLE;
              busy <= 1'b0;
            end else if (two_cycle) begin
              cyc_start <= 1'b1;
              cyc_write <= 1'b1;
              cyc_addr <= addr_reg; // same word / sector / protection location [R01] [R13] [R19]
              cyc_wdata <= (op_reg == `OP_ERASE) ? {8'h00, `CMD_CONFIRM} : data_reg;
              state_reg <= P_SECOND;
            end else if (op_reg == `OP_READ_STATUS || op_reg == `OP_SUSPEND
                         || (poll_reg && op_reg == `OP_RESUME)) begin
              cyc_start <= 1'b1;
              cyc_write <= 1'b0;
              state_reg <= P_POLL; // suspend takes a bounded time; poll ready [R23]
            end else begin
              state_reg <= P_IDLE;
              busy <= 1'b0;
            end
          end
        end
        P_SECOND: begin
          if (cyc_done) begin
            if (poll_reg) begin
              cyc_start <= 1'b1;
              cyc_write <= 1'b0;
              state_reg <= P_POLL;
            end else begin
              state_reg <= P_IDLE;
              busy <= 1'b0;
            end
          end
        end
        P_POLL: begin
          if (cyc_done) begin
            // device flags are sticky, so the latest word holds a whole series [R21]
            status_reg <= cyc_rdata[7:0]; // [R22]
            if (cyc_rdata[`ST_READY]) begin
              state_reg <= P_IDLE;
              busy <= 1'b0;
            end else begin
              cyc_start <= 1'b1; // each read is a new ce strobe [R02]
              cyc_write <= 1'b0;
            end
          end
        end
        default: state_reg <= P_IDLE;
      endcase
      // a clear command drops the cached error flags as the device does [R10]
      if (state_reg == P_FIRST && cyc_done && op_reg == `OP_CLEAR)
        status_reg <= status_reg & 8'hc4;
    end
  end
endmodule // flash_seq_host

// [sim/flash_dev_model.sv]
// behavioural flash device answering the host's command cycles
`timescale 1ns/1ps
module flash_dev_model #(parameter int PROG_T = 300, parameter int ERASE_T = 600) (
  input wire [19:0] fa,
  input wire [15:0] dq_o,
  input wire dq_oe,
  input wire ce_n,
  input wire oe_n,
  input wire we_n,
  output wire [15:0] dq_i
);
  logic [15:0] mem [0:1023];
  logic [7:0] st = 8'h80, snap = 8'h80, pend = 8'h00, d;
  logic arr = 1, lock = 0, vbad = 0, efail = 0, ers = 0;
  int left = 0;
  wire rd = !ce_n && !oe_n;
  wire wr = !ce_n && !we_n;
  wire [15:0] v = arr ? mem[fa[9:0]] : {8'h00, snap};
  // released pins show the inverse so a stale value cannot pass
  assign dq_i = dq_oe ? dq_o : rd ? v : ~v;
  always @(posedge rd) snap = st;
  always #10 begin
    if (left > 0 && !st[6] && !st[2]) left--;
    st[7] = left == 0 || st[6] || st[2];
  end
  always @(negedge wr) begin
    d = dq_o[7:0];
    arr = pend == 8'h00 && d == 8'hff;
    if (pend == 8'h40 || pend == 8'hc0) begin
      if (vbad || st[3]) st |= 8'h18;
      else if (lock) st |= 8'h12;
      else if (pend == 8'hc0 && (fa[19:8] != 0 || fa[7:0] < 8'h81 || fa[7:0] > 8'h88))
        st |= 8'h10;
      else begin
        mem[fa[9:0]] = dq_o;
        left = PROG_T;
        ers = 0;
      end
      pend = 8'h00;
    end else if (pend == 8'h20) begin
      if (d != 8'hd0) st |= 8'h30;
      else if (lock) st |= 8'h22;
      else if (efail) st |= 8'h20;
      else begin
        left = ERASE_T;
        ers = 1;
      end
      pend = 8'h00;
    end else case (d)
      8'h50: st &= 8'hc5;
      8'hb0: if (left > 0) st[ers ? 6 : 2] = 1;
      8'hd0: st &= 8'hbb;
      // one-cycle codes leave no second cycle pending, so a later ff still reads the array
      8'hff, 8'h70: pend = 8'h00;
      default: pend = d;
    endcase
  end
endmodule // flash_dev_model

// [sim/flash_seq_host_asserts.sv]
// assertion checker on the host sequencer's apb and flash pins
`timescale 1ns/1ps
module flash_seq_host_asserts (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire [19:0] fa,
  input wire [15:0] dq_o,
  input wire dq_oe,
  input wire ce_n,
  input wire oe_n,
  input wire we_n,
  input wire busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_APB_ANSWER: assert property (psel && !penable |=> pready) else $error("no answer");
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready held");
  AST_ERR_ALIGN: assert property (pslverr |-> pready) else $error("error without ready");
  AST_STROBE_BUSY: assert property ($fell(ce_n) |-> busy) else $error("strobe while idle");
  AST_WRITE_HOLD: assert property ($fell(we_n) |=> !we_n [*8])
    else $error("write strobe short");
  AST_WRITE_DRIVE: assert property (!we_n |-> dq_oe && !ce_n && oe_n)
    else $error("write without drive");
  AST_WRITE_STEADY: assert property (!we_n && !$past(we_n) |-> $stable(fa) && $stable(dq_o))
    else $error("write data moved");
  AST_READ_FLOAT: assert property (!oe_n |-> !dq_oe && !ce_n && we_n)
    else $error("read while driving");
  AST_STATUS_GAP: assert property ($rose(ce_n) |=> ce_n [*7])
    else $error("chip select gap short");
  cover property ($fell(we_n));
  cover property ($fell(oe_n));
  cover property (pslverr);
endmodule // flash_seq_host_asserts
bind flash_seq_host flash_seq_host_asserts flash_seq_host_asserts_inst (.pclk, .presetn,
  .psel, .penable, .pready, .pslverr, .fa, .dq_o, .dq_oe, .ce_n, .oe_n, .we_n, .busy);

// [sim/testbench.sv]
// self-checking bench: host sequencer against a behavioural flash device
`timescale 1ns/1ps
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic dq_oe, ce_n, oe_n, we_n, busy;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] dq_i, dq_o;
  logic [19:0] fa;
  int n_mismatch = 0, checks_done = 0, i;
  always #5 pclk = ~pclk;
  flash_seq_host flash_seq_host_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .dq_i, .fa, .dq_o, .dq_oe, .ce_n, .oe_n, .we_n, .busy);
  flash_dev_model flash_dev_model_inst (.fa, .dq_o, .dq_oe, .ce_n, .oe_n, .we_n, .dq_i);
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (e !== g) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      n_mismatch++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    i = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && ++i < 20);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (i == 20) begin
      n_mismatch++;
      print_verdict;
    end
  endtask
  // ctrl write, then poll until the host drops its busy bit
  task op(input logic [31:0] c);
    apb(1, 12'h000, c);
    repeat (900) begin
      apb(0, 12'h00c, 32'h0);
      if (rd[8] === 1'b0) return;
    end
    n_mismatch++;
    print_verdict;
  endtask
  task st(input logic [7:0] e);
    apb(0, 12'h00c, 32'h0);
    chk("status", {24'h0, e}, {24'h0, rd[7:0]});
  endtask
  task clr;
    op(32'h6);
    op(32'h8);
    st(8'h80);
  endtask
  task t_prog;
    apb(1, 12'h004, 32'h00000123);
    apb(1, 12'h008, 32'h0000a5c3);
    op(32'h11);
    st(8'h80);
    chk("cell", 32'ha5c3, {16'h0, flash_dev_model_inst.mem[10'h123]});
    op(32'h5);
    op(32'h9);
    apb(0, 12'h010, 32'h0);
    chk("word", 32'ha5c3, {16'h0, rd[15:0]});
    apb(0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    $display("program test done");
  endtask
  task t_errors;
    flash_dev_model_inst.lock = 1;
    op(32'h11);
    st(8'h92);
    op(32'h2);
    chk("erase refused", 32'h1, {31'h0, rd[9]});
    flash_dev_model_inst.lock = 0;
    clr;
    flash_dev_model_inst.vbad = 1;
    op(32'h11);
    st(8'h98);
    flash_dev_model_inst.vbad = 0;
    op(32'h11);
    chk("program refused", 32'h1, {31'h0, rd[9]});
    clr;
    flash_dev_model_inst.efail = 1;
    op(32'h12);
    st(8'ha0);
    flash_dev_model_inst.efail = 0;
    op(32'h11);
    st(8'ha0);
    clr;
    $display("error test done");
  endtask
  task t_susp;
    op(32'h2);
    op(32'h3);
    st(8'hc0);
    op(32'h14);
    st(8'h80);
    op(32'h1);
    op(32'h3);
    st(8'h84);
    op(32'h5);
    op(32'h9);
    apb(0, 12'h010, 32'h0);
    chk("suspended read", 32'ha5c3, {16'h0, rd[15:0]});
    op(32'h14);
    st(8'h80);
    $display("suspend test done");
  endtask
  task t_prot;
    apb(1, 12'h004, 32'h00000085);
    apb(1, 12'h008, 32'h00001234);
    op(32'h17);
    st(8'h80);
    chk("prot cell", 32'h1234, {16'h0, flash_dev_model_inst.mem[10'h085]});
    apb(1, 12'h004, 32'h00000090);
    op(32'h17);
    st(8'h90);
    clr;
    $display("protection test done");
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    t_prog;
    t_errors;
    t_susp;
    t_prot;
    print_verdict;
  end
endmodule // testbench
